// >>> core/hbc_core.sv
/*
  H-bridge control and protection core. Decodes the direction pair, runs soft start and
  voltage-regulation PWM, filters current limit and overcurrent, and drives the fault output.
  Assumes direction inputs and comparator levels are asynchronous and are synchronised here;
  undervoltage is a level that acts as a reset, and power cycling releases the overcurrent latch.
*/
`timescale 1ns/10ps
`default_nettype none

module hbc_core #(
  parameter int unsigned FLT_CYC = hbc_pkg::ILIM_FLT_CYC,  // Current-limit fault time
  parameter int unsigned RAMP_STEP = hbc_pkg::RAMP_STEP_CYC  // Cycles per duty step
) (
  input  wire logic               mclk_i,              // Core clock
  input  wire logic               rst_i,               // Async reset, power-on
  input  wire logic               dir_ctrl_a_i,        // Direction input a
  input  wire logic               dir_ctrl_b_i,        // Direction input b
  input  wire hbc_pkg::hbc_sense_t sense_i,            // Comparator levels
  input  wire logic               undervoltage_lockout_i, // Supply below threshold
  output var  hbc_pkg::hbc_leg_t  bridge_out_a_o,      // Leg a switches
  output var  hbc_pkg::hbc_leg_t  bridge_out_b_o,      // Leg b switches
  output logic                    fault_flag_low_o,    // Open-drain fault, low active
  output logic                    fault_flag_low_oe_o, // Drives the fault pin low when high
  output logic                    overcurrent_shutdown_o, // Latched overcurrent status
  output logic                    thermal_shutdown_o   // Thermal disable status
);

  localparam int unsigned SW     = 10;               // Synchronised bit count
  localparam int unsigned DUTY_W = hbc_pkg::DUTY_W;  // Duty and phase width
  localparam int unsigned CNT_W  = hbc_pkg::CNT_W;   // Wide timer width
  // Bit order of the synchronised word: pins a and b on top, then the sense struct,
  // so over_temp lands in bit 0 and the four switch comparators in bits 4 down to 1

  hbc_pkg::hbc_state_t st_reg;   // Registered state
  hbc_pkg::hbc_state_t st_next;  // Next state
  logic [SW-1:0] sy1_reg, sy2_reg, sy3_reg;  // Three-stage synchronisers
  logic [SW-1:0] raw;            // Raw asynchronous inputs
  logic [SW-1:0] stab_reg;       // Accepted input levels
  logic [SW-1:0] stab_next;
  logic          uv_reg;         // Undervoltage held through sync
  logic [1:0]    uv_sy_reg;
  hbc_pkg::hbc_mode_t mode_in;   // Mode decoded from inputs
  logic          oc_any;         // Any switch overcurrent
  logic          pwm_on;         // PWM on-phase
  logic          disabled;       // Bridge must be off

  assign raw = {dir_ctrl_a_i, dir_ctrl_b_i, sense_i};

  // Input synchronisers: a change counts once stages two and three agree
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_reg  <= '0;
      sy2_reg  <= '0;
      sy3_reg  <= '0;
      stab_reg <= '0;
    end else begin
      sy1_reg  <= raw;
      sy2_reg  <= sy1_reg;
      sy3_reg  <= sy2_reg;
      stab_reg <= stab_next;
    end
  end

  // Per-bit acceptance keeps a half-settled edge from flickering through
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_acc
      assign stab_next[gi] = (sy2_reg[gi] == sy3_reg[gi]) ? sy3_reg[gi] : stab_reg[gi];
    end
  endgenerate

  // Undervoltage sync; acts as an internal reset of the state register except the latch; synchronisers keep running
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_sy_reg <= 2'h0;
      uv_reg    <= 1'b0;
    end else begin
      uv_sy_reg <= {uv_sy_reg[0], undervoltage_lockout_i};
      uv_reg    <= uv_sy_reg[1];
    end
  end

  assign mode_in = hbc_pkg::hbc_mode_t'({stab_reg[9], stab_reg[8]});
  assign oc_any  = stab_reg[4] | stab_reg[3] | stab_reg[2] | stab_reg[1];

  // Next-state logic for mode, ramp, regulation and protection
  always_comb begin
    st_next = st_reg;
    st_next.mode = mode_in;
    // PWM period counter
    if (st_reg.phase >= DUTY_W'(hbc_pkg::PWM_PERIOD - 1)) begin
      st_next.phase = '0;
    end else begin
      st_next.phase = st_reg.phase + DUTY_W'(1);
    end
    // Soft start on entry into a drive mode from brake or sleep
    if ((mode_in == hbc_pkg::HBC_FORWARD || mode_in == hbc_pkg::HBC_REVERSE) &&
        (st_reg.mode == hbc_pkg::HBC_SLEEP || st_reg.mode == hbc_pkg::HBC_BRAKE)) begin
      st_next.duty     = '0;
      st_next.ramping  = 1'b1;
      st_next.ramp_cnt = '0;
    end else if (st_reg.ilim_act && st_reg.duty != '0) begin
      st_next.duty = st_reg.duty - DUTY_W'(1);
    end else if (st_reg.ramp_cnt >= CNT_W'(RAMP_STEP - 1)) begin
      st_next.ramp_cnt = '0;
      // One step per ramp interval, so the ramp is slow and regulation settles
      if (stab_reg[6] || stab_reg[7]) begin
        if (st_reg.duty < DUTY_W'(hbc_pkg::PWM_PERIOD)) begin
          st_next.duty = st_reg.duty + DUTY_W'(1);
        end else begin
          st_next.ramping = 1'b0;
        end
      end else if (st_reg.duty != '0) begin
        st_next.duty    = st_reg.duty - DUTY_W'(1);
        st_next.ramping = 1'b0;
      end
    end else begin
      st_next.ramp_cnt = st_reg.ramp_cnt + CNT_W'(1);
    end
    // Current-limit filter: sense above limit for 3 us
    if (stab_reg[5]) begin
      if (st_reg.ilim_cnt >= 9'(hbc_pkg::ILIM_CYC)) begin
        st_next.ilim_act = 1'b1;
      end else begin
        st_next.ilim_cnt = st_reg.ilim_cnt + 9'h001;
      end
    end else begin
      st_next.ilim_cnt = '0;
      st_next.ilim_act = 1'b0;
    end
    // Long deglitch: fault registers after 275 ms of limiting
    if (st_reg.ilim_act) begin
      if (st_reg.flt_cnt >= CNT_W'(FLT_CYC - 1)) begin
        st_next.ilim_fault = 1'b1;
      end else begin
        st_next.flt_cnt = st_reg.flt_cnt + CNT_W'(1);
      end
    end else begin
      st_next.flt_cnt    = '0;
      st_next.ilim_fault = 1'b0;
    end
    if (mode_in == hbc_pkg::HBC_SLEEP) begin
      st_next.ilim_fault = 1'b0;
      st_next.flt_cnt    = '0;
    end
    // Overcurrent deglitch then permanent latch
    if (oc_any && !st_reg.ocp_latch) begin
      if (st_reg.ocp_cnt >= 8'(hbc_pkg::OCP_CYC - 1)) begin
        st_next.ocp_latch = 1'b1;
      end else begin
        st_next.ocp_cnt = st_reg.ocp_cnt + 8'h01;
      end
    end else begin
      st_next.ocp_cnt = '0;
    end
    // Wake pulse on sleep exit
    if (st_reg.mode == hbc_pkg::HBC_SLEEP && mode_in != hbc_pkg::HBC_SLEEP) begin
      st_next.wake_cnt = 8'(hbc_pkg::WAKE_CYC);
    end else if (st_reg.wake_cnt != '0) begin
      st_next.wake_cnt = st_reg.wake_cnt - 8'h01;
    end
    // Undervoltage resets internal logic; latch survives since only power cycle clears it
    if (uv_reg) begin
      st_next           = '0;
      st_next.ocp_latch = st_reg.ocp_latch;
    end
  end

  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwm_on   = st_reg.phase < st_reg.duty;
  assign disabled = st_reg.ocp_latch | stab_reg[0] | uv_reg;

  // Bridge drive; outputs are registered to avoid decode glitches on the gates
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bridge_out_a_o <= '0;
      bridge_out_b_o <= '0;
    end else if (disabled || st_reg.mode == hbc_pkg::HBC_SLEEP) begin
      bridge_out_a_o <= '0;
      bridge_out_b_o <= '0;
    end else if (st_reg.mode == hbc_pkg::HBC_BRAKE) begin
      bridge_out_a_o <= '{hs: 1'b1, ls: 1'b0};
      bridge_out_b_o <= '{hs: 1'b1, ls: 1'b0};
    end else if (!pwm_on) begin
      bridge_out_a_o <= '{hs: 1'b1, ls: 1'b0};
      bridge_out_b_o <= '{hs: 1'b1, ls: 1'b0};
    end else if (st_reg.mode == hbc_pkg::HBC_FORWARD) begin
      bridge_out_a_o <= '{hs: 1'b1, ls: 1'b0};
      bridge_out_b_o <= '{hs: 1'b0, ls: 1'b1};
    end else begin
      bridge_out_a_o <= '{hs: 1'b0, ls: 1'b1};
      bridge_out_b_o <= '{hs: 1'b1, ls: 1'b0};
    end
  end

  // Fault pin: open drain, pulled low for any active cause
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_flag_low_oe_o <= 1'b0;
    end else begin
      fault_flag_low_oe_o <= st_reg.ilim_fault | st_reg.ocp_latch | stab_reg[0] |
                             uv_reg | (st_reg.wake_cnt != '0);
    end
  end

  assign fault_flag_low_o       = 1'b0;
  assign overcurrent_shutdown_o = st_reg.ocp_latch;
  assign thermal_shutdown_o     = stab_reg[0];

  // Entry into a drive mode straight from brake
  sequence brake_exit_s;
    (mode_in == hbc_pkg::HBC_FORWARD || mode_in == hbc_pkg::HBC_REVERSE) &&
      st_reg.mode == hbc_pkg::HBC_BRAKE;
  endsequence

  // First cycle out of sleep
  sequence sleep_exit_s;
    st_reg.mode == hbc_pkg::HBC_SLEEP && mode_in != hbc_pkg::HBC_SLEEP;
  endsequence

  // Sleep drives both legs off
  sleep_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_reg.mode == hbc_pkg::HBC_SLEEP |=> bridge_out_a_o == '0 && bridge_out_b_o == '0)
    else $error("bridge driven in sleep");

  // Entry into drive from brake restarts duty at zero
  ramp_start_a: assert property (@(posedge mclk_i) disable iff (rst_i || uv_reg)
    brake_exit_s |=> st_reg.duty == '0)
    else $error("ramp did not start at zero");

  // Sleep clears the current-limit fault
  sleep_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    mode_in == hbc_pkg::HBC_SLEEP |=> !st_reg.ilim_fault)
    else $error("fault survived sleep");

  // Sleep exit gives a fault pulse two cycles on
  wake_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i || uv_reg)
    sleep_exit_s |=> ##1 fault_flag_low_oe_o)
    else $error("no wake pulse");

  // Off-phase in reverse mode turns both high sides on
  recirc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !disabled && st_reg.mode == hbc_pkg::HBC_REVERSE && !pwm_on |=>
      bridge_out_a_o.hs && bridge_out_b_o.hs)
    else $error("no recirculation");

  // Limit active needs the sense filter count reached
  ilim_filter_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(st_reg.ilim_act) |-> $past(st_reg.ilim_cnt) == 9'(hbc_pkg::ILIM_CYC))
    else $error("limit without filter");

  // Overcurrent latch never releases
  ocp_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_reg.ocp_latch |=> st_reg.ocp_latch && bridge_out_a_o == '0)
    else $error("overcurrent latch released");

  // Overtemperature turns leg b off and asserts fault
  thermal_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    stab_reg[0] |=> bridge_out_b_o == '0 && fault_flag_low_oe_o)
    else $error("bridge on while hot");

  // Undervoltage turns the bridge off and pulls the fault pin
  uv_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    uv_reg |=> bridge_out_a_o == '0 && bridge_out_b_o == '0 && fault_flag_low_oe_o)
    else $error("bridge on in lockout");

  // With no cause left the fault pin is released
  fault_release_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !st_reg.ilim_fault && !st_reg.ocp_latch && !stab_reg[0] && !uv_reg &&
      st_reg.wake_cnt == '0 |=> !fault_flag_low_oe_o)
    else $error("fault pin held without cause");

  // Brake puts both high sides on
  brake_legs_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !disabled && st_reg.mode == hbc_pkg::HBC_BRAKE |=>
      bridge_out_a_o == 2'h2 && bridge_out_b_o == 2'h2)
    else $error("brake pattern wrong");

  // Forward on-phase drives leg a high and leg b low
  forward_on_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !disabled && st_reg.mode == hbc_pkg::HBC_FORWARD && pwm_on |=>
      bridge_out_a_o == 2'h2 && bridge_out_b_o == 2'h1)
    else $error("forward drive wrong");

  // Overcurrent held for the deglitch time sets the latch
  ocp_trip_a: assert property (@(posedge mclk_i) disable iff (rst_i || uv_reg)
    oc_any && !st_reg.ocp_latch && st_reg.ocp_cnt == 8'(hbc_pkg::OCP_CYC - 1) |=>
      st_reg.ocp_latch)
    else $error("overcurrent did not latch");

  // Limit gone clears the current-limit fault next cycle
  ilim_self_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !st_reg.ilim_act |=> !st_reg.ilim_fault)
    else $error("limit fault stuck");

  // Current-limit fault drives fault pin next cycle
  ilim_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_reg.ilim_fault |=> fault_flag_low_oe_o)
    else $error("fault pin idle with fault");

endmodule

`default_nettype wire

// >>> core/hbc_pkg.sv
/*
  Package for the H-bridge control and fault logic: the state carrier types, the timing
  counts derived from the 100 MHz clock, and the PWM and ramp constants.
  Assumes a single clock mclk_i at 100 MHz and that analog comparators arrive as plain levels.
*/
package hbc_pkg;

  localparam int unsigned CLK_HZ         = 100_000_000;  // Core clock rate
  localparam int unsigned PWM_FREQ_HZ    = 44_500;       // Regulation PWM rate
  localparam int unsigned PWM_PERIOD     = CLK_HZ / PWM_FREQ_HZ;  // Cycles per PWM period
  localparam int unsigned DUTY_W         = 12;           // Duty and period counter width
  localparam int unsigned RAMP_MS        = 12;           // Sleep to full duty ramp
  localparam int unsigned RAMP_CYC       = RAMP_MS * (CLK_HZ / 1000);
  localparam int unsigned RAMP_STEP_CYC  = RAMP_CYC / PWM_PERIOD;  // Cycles per duty step
  localparam int unsigned ILIM_NS        = 3000;         // Current-limit filter time
  localparam int unsigned ILIM_CYC       = (ILIM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned ILIM_FLT_MS    = 275;          // Current-limit fault deglitch
  localparam int unsigned ILIM_FLT_CYC   = ILIM_FLT_MS * (CLK_HZ / 1000);
  localparam int unsigned OCP_NS         = 2000;         // Overcurrent deglitch
  localparam int unsigned OCP_CYC        = (OCP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WAKE_NS        = 1000;         // Sleep-exit fault pulse width
  localparam int unsigned WAKE_CYC       = (WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W          = 25;           // Wide timer width

  // Bridge mode decoded from the direction pair
  typedef enum logic [1:0] {
    HBC_SLEEP   = 2'h0,
    HBC_REVERSE = 2'h1,
    HBC_BRAKE   = 2'h3,
    HBC_FORWARD = 2'h2
  } hbc_mode_t;

  // One bridge leg: high side on, low side on
  typedef struct packed {
    logic hs;
    logic ls;
  } hbc_leg_t;

  // Analog comparator levels coming in from the power stage
  typedef struct packed {
    logic avg_below;    // Averaged output / 4 below setpoint
    logic set_over_vcc; // Programmed voltage above supply
    logic sense_over;   // Sense node above limit voltage
    logic oc_hs_a;      // Overcurrent on each switch
    logic oc_ls_a;
    logic oc_hs_b;
    logic oc_ls_b;
    logic over_temp;    // Die temperature above threshold
  } hbc_sense_t;

  // Control state of the block; synchronisers, undervoltage sync and output registers sit outside it
  typedef struct packed {
    hbc_mode_t         mode;        // Debounced mode
    logic [DUTY_W-1:0] duty;        // Regulation duty
    logic [DUTY_W-1:0] phase;       // PWM period counter
    logic [CNT_W-1:0]  ramp_cnt;    // Ramp step timer
    logic              ramping;     // Soft start active
    logic [8:0]        ilim_cnt;    // Sense filter, wide enough for the 3 us count
    logic              ilim_act;    // Current limit active
    logic [CNT_W-1:0]  flt_cnt;     // Long fault deglitch
    logic              ilim_fault;  // Current-limit fault flag
    logic [7:0]        ocp_cnt;     // Overcurrent deglitch
    logic              ocp_latch;   // Latched shutdown
    logic [7:0]        wake_cnt;    // Wake pulse timer
  } hbc_state_t;

endpackage

// >>> test/hbc_host.sv
/*
  Host model: drives the direction pair from a requested mode and resolves the
  open-drain fault line. Assumes a pull-up on the fault line and the bench clock.
*/
`timescale 1ns/10ps
`default_nettype none

module hbc_host (
  input  wire logic               mclk_i,    // Bench clock, unused by the pins
  input  wire hbc_pkg::hbc_mode_t cmd_i,     // Requested mode, changed at falling edges
  input  wire logic               flt_d_i,   // Fault pin data from the device
  input  wire logic               flt_oe_i,  // Device sinks the fault pin when high
  output logic                    dir_a_o,   // Direction input a
  output logic                    dir_b_o,   // Direction input b
  output logic                    flt_pin_o  // Level seen by the host
);
  // Levels only, never a fast train; modulation keeps one pin high
  assign dir_a_o = cmd_i[1];
  assign dir_b_o = cmd_i[0];
  // Pull-up wins whenever the device lets go of the line
  assign flt_pin_o = flt_oe_i ? flt_d_i : 1'b1;
endmodule

`default_nettype wire

// >>> test/hbc_core_bench.sv
/*
  Self-checking bench for the H-bridge control core with a host model.
  Assumes shortened fault and ramp counts; comparator levels are driven directly.
*/
`timescale 1ns/10ps
`default_nettype none

module hbc_core_bench;
  logic               mclk;         // 100 MHz clock
  logic               rst;          // Power-on reset
  hbc_pkg::hbc_mode_t cmd;          // Mode the host asks for
  hbc_pkg::hbc_sense_t sense;       // Comparator levels
  logic               undervoltage_lockout;         // Supply low
  logic               dir_a, dir_b; // Direction pins
  hbc_pkg::hbc_leg_t  leg_a, leg_b; // Bridge gates
  logic               flt_d, flt_oe, flt_pin, overcurrent_shutdown, thermal_shutdown;
  logic [3:0]         br;           // Both legs in one word
  int                 error_cnt, checks_done, n;
  assign br = {leg_a, leg_b};

  hbc_host i_host (.mclk_i(mclk), .cmd_i(cmd), .flt_d_i(flt_d), .flt_oe_i(flt_oe),
                   .dir_a_o(dir_a), .dir_b_o(dir_b), .flt_pin_o(flt_pin));
  // Short counts keep the run small; expectations use the same figures
  hbc_core #(.FLT_CYC(200), .RAMP_STEP(4)) i_dut (
    .mclk_i(mclk), .rst_i(rst), .dir_ctrl_a_i(dir_a), .dir_ctrl_b_i(dir_b),
    .sense_i(sense), .undervoltage_lockout_i(undervoltage_lockout), .bridge_out_a_o(leg_a),
    .bridge_out_b_o(leg_b), .fault_flag_low_o(flt_d), .fault_flag_low_oe_o(flt_oe),
    .overcurrent_shutdown_o(overcurrent_shutdown), .thermal_shutdown_o(thermal_shutdown));

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Gate pattern for a mode in the on or off phase of the PWM
  function automatic logic [3:0] exp_br(input hbc_pkg::hbc_mode_t m, input logic on);
    case (m)
      hbc_pkg::HBC_SLEEP:   return 4'h0;
      hbc_pkg::HBC_FORWARD: return on ? 4'h9 : 4'hA;
      hbc_pkg::HBC_REVERSE: return on ? 4'h6 : 4'hA;
      default:              return 4'hA;
    endcase
  endfunction

  task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(negedge mclk);
  endtask

  task automatic go(input hbc_pkg::hbc_mode_t m, input int c);
    cmd = m;
    step(c);
  endtask

  // On-phase cycles over one PWM period
  task automatic count_on(output int k);
    k = 0;
    repeat (hbc_pkg::PWM_PERIOD) begin
      @(negedge mclk);
      if (br === exp_br(cmd, 1'b1)) k++;
    end
  endtask

  task automatic do_reset;
    rst = 1'b1;
    step(3);
    rst = 1'b0;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #900_000;
    error_cnt++;
    complete_run();
  end

  initial begin
    error_cnt = 0;
    checks_done = 0;
    cmd = hbc_pkg::HBC_SLEEP;
    sense = '0;
    undervoltage_lockout = 1'b0;
    void'($urandom(32'hB540));
    do_reset();
    check(br, 4'h0, "reset gates");
    check({3'h0, flt_pin}, 4'h1, "reset fault");
    // Wake pulse, zero duty off-phase, decode of brake and sleep
    go(hbc_pkg::HBC_FORWARD, 10);
    check({3'h0, flt_pin}, 4'h0, "wake pulse");
    check(br, 4'hA, "start duty");
    step(110);
    check({3'h0, flt_pin}, 4'h1, "pulse end");
    check(br, 4'hA, "duty held low");
    go(hbc_pkg::HBC_BRAKE, 10);
    check(br, 4'hA, "brake");
    go(hbc_pkg::HBC_SLEEP, 10);
    check(br, 4'h0, "sleep");
    $display("test decode done");
    // Ramp, then full duty with regulation bypassed; second ramp starts from brake
    sense.set_over_vcc = 1'b1;
    for (int i = 0; i < 2; i++) begin
      go(i == 0 ? hbc_pkg::HBC_FORWARD : hbc_pkg::HBC_REVERSE, 4500);
      count_on(n);
      check({3'h0, n > 500 && n < 2000}, 4'h1, "mid ramp");
      step(4600);
      repeat (4) begin
        step($urandom_range(1, 2000));
        check(br, exp_br(cmd, 1'b1), "full duty");
      end
      if (i == 0) begin
        go(hbc_pkg::HBC_BRAKE, 10);
        check(br, 4'hA, "brake at full duty");
      end
    end
    $display("test ramp done");
    // Regulation both ways
    sense.set_over_vcc = 1'b0;
    step(9100);
    check(br, 4'hA, "duty lowered");
    sense.avg_below = 1'b1;
    step(9100);
    check(br, exp_br(cmd, 1'b1), "duty raised");
    $display("test regulation done");
    // Thermal shutdown and recovery
    sense.over_temp = 1'b1;
    step(10);
    check(br, 4'h0, "hot gates");
    check({2'h0, thermal_shutdown, flt_pin}, 4'h2, "hot flags");
    sense.over_temp = 1'b0;
    step(10);
    check({1'h0, thermal_shutdown, flt_pin, br != 4'h0}, 4'h3, "cooled");
    $display("test thermal done");
    // Current limit: filter, long fault, self-clear, clear by sleep
    sense.sense_over = 1'b1;
    step(400);
    check({3'h0, flt_pin}, 4'h1, "limit early");
    step(200);
    check({2'h0, flt_pin, br != 4'h0}, 4'h1, "limit fault");
    step(1500);
    count_on(n);
    check({3'h0, n < hbc_pkg::PWM_PERIOD}, 4'h1, "duty cut");
    sense.sense_over = 1'b0;
    step(20);
    check({3'h0, flt_pin}, 4'h1, "limit gone");
    sense.sense_over = 1'b1;
    step(600);
    go(hbc_pkg::HBC_SLEEP, 10);
    check({3'h0, flt_pin}, 4'h1, "sleep clears");
    sense.sense_over = 1'b0;
    $display("test limit done");
    // Undervoltage lockout and resume
    go(hbc_pkg::HBC_FORWARD, 200);
    undervoltage_lockout = 1'b1;
    step(10);
    check(br, 4'h0, "lockout gates");
    check({3'h0, flt_pin}, 4'h0, "lockout fault");
    undervoltage_lockout = 1'b0;
    step(20);
    check({3'h0, br != 4'h0}, 4'h1, "resume");
    $display("test lockout done");
    // Each switch: a short glitch passes, a long one latches
    for (int i = 0; i < 4; i++) begin
      do_reset();
      go(hbc_pkg::HBC_FORWARD, 20);
      sense[4-i] = 1'b1;
      step($urandom_range(20, 150));
      sense[4-i] = 1'b0;
      step(10);
      check({3'h0, overcurrent_shutdown}, 4'h0, "glitch");
      sense[4-i] = 1'b1;
      step(260);
      sense[4-i] = 1'b0;
      step(60);
      check({3'h0, overcurrent_shutdown}, 4'h1, "latched");
      check(br, 4'h0, "latched gates");
      check({3'h0, flt_pin}, 4'h0, "latched fault");
    end
    $display("test overcurrent done");
    complete_run();
  end
endmodule

`default_nettype wire
